// >>> fbc_status.sv
// Fieldbus card configuration, rate detection, slave state machine and lamps.
`timescale 1ns/1ns
module fbc_status
    import fbc_pkg::*;
#(
    parameter int FLASH_CYCLES = FLASH_CYC,
    parameter int LOCK_BITS = 16
) (
    // Clock, reset and enable.
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    // Pins: switches, serial fit strap and bus receive line.
    input wire logic [8:0] dip_sw,
    input wire logic serial_fitted,
    input wire logic bus_rx,
    // Same-domain inputs.
    input wire fbc_evt_s evt,
    input wire fbc_fault_s faults,
    // Outputs.
    output fbc_lamp_s lamps,
    output fbc_state_e state,
    output logic [6:0] node_addr,
    output logic [1:0] serial_baud_sel,
    output logic [17:0] serial_baud,
    output logic serial_baud_sw,
    output logic rate_locked,
    output logic [3:0] rate_index,
    output logic cyclic_pulse,
    output logic acyclic_pulse
);

    // ****************************************************************
    // Pin synchronisers.
    // ****************************************************************
    logic [10:0] meta_q;
    logic [10:0] sync_q;
    logic rx_prev_q;

    // Two flops on every pin input before any logic reads it. The receive
    // bit resets to the idle-high line level, so no false edge follows reset.
    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_q <= 11'h400;
            sync_q <= 11'h400;
            rx_prev_q <= 1'b1;
        end else if (clk_en) begin
            meta_q <= {bus_rx, serial_fitted, dip_sw};
            sync_q <= meta_q;
            rx_prev_q <= sync_q[10];
        end
    end

    wire logic [8:0] sw_s = sync_q[8:0];
    wire logic fitted_s = sync_q[9];
    wire logic rx_s = sync_q[10];

    // ****************************************************************
    // Switch decoding.
    // ****************************************************************
    function automatic logic [17:0] baud_of(input logic [1:0] code);
        case (code)
            BAUD_9600: baud_of = SER_9600;
            BAUD_115200: baud_of = SER_115200;
            BAUD_19200: baud_of = SER_19200;
            default: baud_of = 18'h00000;
        endcase
    endfunction

    logic addr_bad_q;

    // Address always from switches 1..7; baud bits used only with the port fitted.
    always_ff @(posedge mclk) begin
        if (rst) begin
            node_addr <= 7'h00;
            serial_baud_sel <= 2'h0;
            serial_baud <= 18'h00000;
            serial_baud_sw <= 1'b0;
            addr_bad_q <= 1'b1;
        end else if (clk_en) begin
            node_addr <= sw_s[6:0]; // [RULE1] [RULE3]
            addr_bad_q <= (sw_s[6:0] < ADDR_MIN) || (sw_s[6:0] > ADDR_MAX); // [RULE11]
            if (fitted_s) begin
                serial_baud_sel <= sw_s[8:7]; // [RULE2]
                serial_baud <= baud_of(sw_s[8:7]); // [RULE6]
                serial_baud_sw <= (sw_s[8:7] == BAUD_SW); // [RULE6]
            end else begin
                // Switches 8 and 9 carry no meaning without the port.
                serial_baud_sel <= 2'h0; // [RULE3]
                serial_baud <= 18'h00000;
                serial_baud_sw <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Bus rate detection.
    // ****************************************************************
    // Measures the shortest gap between receive edges, which is one bit
    // time, then snaps it to the nearest listed rate. Short glitches can
    // mislead it, so a lock needs LOCK_BITS plus one agreeing edges in a row.
    logic [15:0] gap_q;
    logic [15:0] min_q;
    logic [3:0] cand_q;
    logic [15:0] agree_q;

    function automatic logic [3:0] nearest(input logic [15:0] len);
        logic [3:0] best;
        best = 4'h0;
        for (int i = 1; i < NUM_RATES; i++) begin
            if ({2'b00, BIT_CYC[i]} + {3'b000, BIT_CYC[i][13:1]} >= len) begin
                best = 4'(i);
            end
        end
        nearest = best;
    endfunction

    wire logic rx_edge = rx_s ^ rx_prev_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            gap_q <= 16'h0000;
            min_q <= 16'hFFFF;
            cand_q <= 4'h0;
            agree_q <= 16'h0000;
            rate_locked <= 1'b0;
            rate_index <= 4'h0;
        end else if (clk_en) begin
            // A bus timeout releases the lock so a new master rate is found.
            // It comes first so that a lock reached on the same edge wins.
            if (evt.timeout) begin
                rate_locked <= 1'b0;
                min_q <= 16'hFFFF;
                agree_q <= 16'h0000;
            end
            if (rx_edge) begin
                gap_q <= 16'h0001;
                if (gap_q != 16'h0000 && gap_q < min_q) begin
                    min_q <= gap_q;
                end
                if (nearest(min_q) == cand_q) begin
                    if (agree_q != 16'(LOCK_BITS)) begin
                        agree_q <= agree_q + 16'h0001;
                    end else begin
                        rate_locked <= 1'b1; // [RULE4]
                        rate_index <= cand_q; // [RULE5]
                    end
                end else begin
                    cand_q <= nearest(min_q); // [RULE5]
                    agree_q <= 16'h0000;
                end
            end else if (gap_q != 16'hFFFF) begin
                gap_q <= gap_q + 16'h0001;
            end
        end
    end

    // ****************************************************************
    // Slave state machine.
    // ****************************************************************
    wire logic any_fault = faults.hw_id | faults.board_rev | faults.base_control_module
        | addr_bad_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= ST_WAIT_PARAM;
        end else if (clk_en) begin
            if (any_fault) begin
                state <= ST_FAULT; // [RULE10] [RULE11]
            end else begin
                case (state)
                    ST_WAIT_PARAM: begin
                        if (evt.param_err) state <= ST_PROTOCOL_ERR;
                        else if (evt.param_ok) state <= ST_WAIT_CFG; // [RULE12]
                    end
                    ST_WAIT_CFG: begin
                        if (evt.cfg_err || evt.param_err) state <= ST_PROTOCOL_ERR;
                        else if (evt.cfg_ok) state <= ST_DATA_EXCH; // [RULE12]
                    end
                    ST_DATA_EXCH: begin
                        if (evt.cfg_err || evt.param_err) state <= ST_PROTOCOL_ERR;
                        else if (evt.timeout) state <= ST_WAIT_PARAM;
                    end
                    ST_PROTOCOL_ERR: begin
                        // A fresh good parameter telegram restarts the sequence.
                        if (evt.param_ok) state <= ST_WAIT_CFG;
                        else if (evt.timeout) state <= ST_WAIT_PARAM;
                    end
                    // Fault clears only once every fault source is gone.
                    ST_FAULT: state <= ST_WAIT_PARAM;
                    default: state <= ST_WAIT_PARAM;
                endcase
            end
        end
    end

    // ****************************************************************
    // Data exchange qualification.
    // ****************************************************************
    // Exchange telegrams are passed on only in the data exchange state.
    always_ff @(posedge mclk) begin
        if (rst) begin
            cyclic_pulse <= 1'b0;
            acyclic_pulse <= 1'b0;
        end else if (clk_en) begin
            cyclic_pulse <= evt.cyclic && state == ST_DATA_EXCH; // [RULE7]
            acyclic_pulse <= evt.acyclic && state == ST_DATA_EXCH; // [RULE7]
        end
    end

    // ****************************************************************
    // Lamps.
    // ****************************************************************
    logic [31:0] flash_cnt_q;
    logic flash_q;

    // Free-running 500 ms toggle so every flashing state shares one phase.
    always_ff @(posedge mclk) begin
        if (rst) begin
            flash_cnt_q <= 32'h0;
            flash_q <= 1'b0;
        end else if (clk_en) begin
            if (flash_cnt_q == 32'(FLASH_CYCLES - 1)) begin
                flash_cnt_q <= 32'h0;
                flash_q <= ~flash_q; // [RULE9]
            end else begin
                flash_cnt_q <= flash_cnt_q + 32'h1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            lamps <= '0;
        end else if (clk_en) begin
            lamps.activity <= state != ST_FAULT; // [RULE8]
            lamps.system_fault_lamp <= state == ST_FAULT; // [RULE8]
            case (state)
                ST_WAIT_PARAM: lamps.bus_fault_lamp <= 1'b1; // [RULE9]
                ST_WAIT_CFG, ST_PROTOCOL_ERR: lamps.bus_fault_lamp <= flash_q; // [RULE9]
                default: lamps.bus_fault_lamp <= 1'b0;
            endcase
        end
    end

endmodule

// >>> fbc_pkg.sv
// Package with constants, types and the rule summary for the fieldbus card status block.
// How it works
// RULE1: With serial port fitted, switches one to seven give node address for both.
// RULE2: With serial port fitted, switches eight and nine give serial baud rate.
// RULE3: Without serial port, switches only form the fieldbus node address.
// RULE4: No configured bus rate; detect the master's rate and lock to it.
// RULE5: Detector recognises 9600 up to 12 Mbit/s, ten rates in all.
// RULE6: Baud bits 00 software, 01 9600, 10 115200, 11 19200.
// RULE7: Cyclic data exchange, plus acyclic parameter exchange.
// RULE8: Green lamp lit in all non-fault states; red system lamp only in fault.
// RULE9: Bus lamp on in parameter wait, off in exchange, flashes 500 ms otherwise; the code keeps it off in fault.
// RULE10: Fault on hardware id, board revision, bad address or base module fault.
// RULE11: Address outside 3 to 125 is invalid and forces fault.
// RULE12: Parameter wait, then configuration wait, then exchange as telegrams are accepted.
package fbc_pkg;

    // ****************************************************************
    // Clock and timing.
    // ****************************************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int FLASH_MS = 500;
    localparam int FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
    localparam int NUM_RATES = 10;

    // ****************************************************************
    // Address limits and serial baud codes.
    // ****************************************************************
    localparam logic [6:0] ADDR_MIN = 7'h03;
    localparam logic [6:0] ADDR_MAX = 7'h7D;
    localparam logic [1:0] BAUD_SW = 2'h0;
    localparam logic [1:0] BAUD_9600 = 2'h1;
    localparam logic [1:0] BAUD_115200 = 2'h2;
    localparam logic [1:0] BAUD_19200 = 2'h3;

    // Baud rates of the serial port, in bit/s.
    localparam logic [17:0] SER_9600 = 18'h02580;
    localparam logic [17:0] SER_19200 = 18'h04B00;
    localparam logic [17:0] SER_115200 = 18'h1C200;

    // Bit periods of the ten bus rates in mclk cycles (9600 down to 12M).
    localparam logic [13:0] BIT_CYC [NUM_RATES] = '{
        14'h28B1, 14'h1458, 14'h0898, 14'h042B, 14'h0215,
        14'h00C8, 14'h0042, 14'h0021, 14'h0011, 14'h0008};

    // ****************************************************************
    // Types.
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_WAIT_PARAM, ST_WAIT_CFG, ST_DATA_EXCH, ST_PROTOCOL_ERR, ST_FAULT
    } fbc_state_e;

    // Telegram events from the protocol engine.
    typedef struct packed {
        logic param_ok;
        logic param_err;
        logic cfg_ok;
        logic cfg_err;
        logic cyclic;
        logic acyclic;
        logic timeout;
    } fbc_evt_s;

    // Lamp outputs.
    typedef struct packed {
        logic activity;
        logic system_fault_lamp;
        logic bus_fault_lamp;
    } fbc_lamp_s;

    // Fault sources.
    typedef struct packed {
        logic hw_id;
        logic board_rev;
        logic base_control_module;
    } fbc_fault_s;

endpackage

// >>> fbc_status_properties.sv
// Concurrent checks on the ports of the fieldbus card status block.
`timescale 1ns/1ns
module fbc_chk
    import fbc_pkg::*;
#(
    parameter int FLASH_CYCLES = FLASH_CYC
) (
    // Clock and inputs.
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [8:0] dip_sw,
    input wire logic serial_fitted,
    input wire fbc_evt_s evt,
    input wire fbc_fault_s faults,
    // Outputs.
    input wire fbc_lamp_s lamps,
    input wire fbc_state_e state,
    input wire logic [6:0] node_addr,
    input wire logic [1:0] serial_baud_sel,
    input wire logic serial_baud_sw,
    input wire logic cyclic_pulse,
    input wire logic acyclic_pulse
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst || !clk_en);

    // Helpers: no fault pending, and a flashing state.
    wire logic ok = faults == 3'h0 && node_addr inside {[ADDR_MIN:ADDR_MAX]};
    wire logic fl = state inside {ST_WAIT_CFG, ST_PROTOCOL_ERR};
    int still_q;

    // Cycles the bus lamp has held still in a flashing state; a stuck lamp
    // would let this run past one flash half-period.
    always_ff @(posedge mclk) begin
        if (rst || !fl || $changed(lamps.bus_fault_lamp)) begin
            still_q <= 0;
        end else if (clk_en) begin
            still_q <= still_q + 1;
        end
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    a_addr_from_sw: assert property ($stable(dip_sw)[*4] |-> node_addr == dip_sw[6:0])
        else $error("node address differs from switches");
    a_baud_sel_map: assert property ($stable({serial_fitted, dip_sw})[*4] |->
        serial_baud_sel == (serial_fitted ? dip_sw[8:7] : 2'h0))
        else $error("baud select wrong");
    a_baud_sw_code: assert property ($stable({serial_fitted, dip_sw})[*4] |->
        serial_baud_sw == (serial_fitted && dip_sw[8:7] == BAUD_SW))
        else $error("software baud flag wrong");
    a_lamps_by_state: assert property (!$past(rst) |->
        lamps.system_fault_lamp == ($past(state) == ST_FAULT) &&
        lamps.activity == ($past(state) != ST_FAULT))
        else $error("green or system lamp wrong");
    a_bus_lamp_level: assert property (!$past(rst) &&
        $past(state) inside {ST_WAIT_PARAM, ST_DATA_EXCH} |->
        lamps.bus_fault_lamp == ($past(state) == ST_WAIT_PARAM))
        else $error("bus lamp level wrong");
    a_bus_lamp_flash: assert property (still_q <= FLASH_CYCLES + 1)
        else $error("bus lamp not flashing");
    a_fault_entry: assert property (faults != 3'h0 |=> state == ST_FAULT)
        else $error("fault not entered");
    a_bad_addr: assert property (!(node_addr inside {[ADDR_MIN:ADDR_MAX]}) |=> state == ST_FAULT)
        else $error("invalid address not faulted");
    a_param_step: assert property (ok && state == ST_WAIT_PARAM && evt.param_ok |=>
        state == ST_WAIT_CFG)
        else $error("no step to configuration wait");
    a_cfg_step: assert property (ok && state == ST_WAIT_CFG && evt.cfg_ok |=>
        state == ST_DATA_EXCH)
        else $error("no step to data exchange");
    a_pulse_exch: assert property (!$past(rst) |->
        cyclic_pulse == ($past(evt.cyclic) && $past(state) == ST_DATA_EXCH) &&
        acyclic_pulse == ($past(evt.acyclic) && $past(state) == ST_DATA_EXCH))
        else $error("exchange pulse wrong");

    c_exchange: cover property (state == ST_DATA_EXCH);
    c_fault: cover property (state == ST_FAULT);
    c_proto_err: cover property (state == ST_PROTOCOL_ERR);
endmodule

bind fbc_status fbc_chk #(.FLASH_CYCLES(FLASH_CYCLES)) u_chk (.mclk, .rst, .clk_en, .dip_sw,
    .serial_fitted, .evt, .faults, .lamps, .state, .node_addr, .serial_baud_sel,
    .serial_baud_sw, .cyclic_pulse, .acyclic_pulse);

// >>> fbc_master.sv
// Bus master model that drives the receive line at one of the bus rates.
`timescale 1ns/1ns
module fbc_master
    import fbc_pkg::*;
(
    // Control from the bench.
    input wire logic mclk,
    input wire logic go,
    input wire logic [3:0] idx,
    // Bus line.
    output logic bus_rx
);
    int cnt;

    // Alternate bits at the chosen rate; the line idles high between bursts.
    always_ff @(posedge mclk) begin
        if (!go) begin
            bus_rx <= 1'b1;
            cnt <= 0;
        end else if (cnt >= int'(BIT_CYC[idx]) - 1) begin
            bus_rx <= !bus_rx;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// >>> fbc_status_bench.sv
// Self-checking bench of the fieldbus card status block.
`timescale 1ns/1ns
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
    $display("BAD %s exp %0h got %0h", n, e, a); end end
module fbc_status_bench
    import fbc_pkg::*;
;
    logic mclk = 1'b0, rst = 1'b1, serial_fitted = 1'b0, go = 1'b0, clk_en = 1'b1, f, b;
    logic [8:0] dip_sw = 9'h000, s;
    logic [3:0] idx = 4'h0, rate_index;
    fbc_evt_s evt = '0;
    fbc_fault_s faults = '0;
    wire logic bus_rx;
    fbc_lamp_s lamps;
    fbc_state_e state;
    logic [6:0] node_addr;
    logic [1:0] serial_baud_sel;
    logic [17:0] serial_baud;
    logic serial_baud_sw, rate_locked, cyclic_pulse, acyclic_pulse;
    int mismatches = 0, comparisons = 0, i, t;
    logic [31:0] seed = 32'h000006EB;
    logic [6:0] corner [4] = '{7'h02, 7'h03, 7'h7D, 7'h7E};
    logic [6:0] evs [11] = '{7'h40, 7'h10, 7'h04, 7'h02, 7'h01, 7'h40, 7'h08, 7'h04, 7'h01,
        7'h20, 7'h01};
    fbc_state_e sts [11] = '{ST_WAIT_CFG, ST_DATA_EXCH, ST_DATA_EXCH, ST_DATA_EXCH,
        ST_WAIT_PARAM, ST_WAIT_CFG, ST_PROTOCOL_ERR, ST_PROTOCOL_ERR, ST_WAIT_PARAM,
        ST_PROTOCOL_ERR, ST_WAIT_PARAM};

    // Short flash period and lock count keep the run brief.
    fbc_status #(.FLASH_CYCLES(6), .LOCK_BITS(2)) u_fbc_status (.mclk, .rst, .clk_en,
        .dip_sw, .serial_fitted, .bus_rx, .evt, .faults, .lamps, .state, .node_addr,
        .serial_baud_sel, .serial_baud, .serial_baud_sw, .rate_locked, .rate_index,
        .cyclic_pulse, .acyclic_pulse);
    fbc_master u_fbc_master (.mclk, .go, .idx, .bus_rx);

    initial forever #5 mclk = !mclk;

    // ****************************************************************
    // Helpers.
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected serial rate; zero when not fitted or left to software.
    function automatic logic [17:0] exp_baud(logic fit, logic [1:0] c);
        if (!fit || c == 2'h0) return 18'h00000;
        return c == 2'h1 ? 18'h02580 : c == 2'h2 ? 18'h1C200 : 18'h04B00;
    endfunction

    // Sends one telegram event, then watches the bus lamp for flashing.
    task automatic step(logic [6:0] v, fbc_state_e want);
        fbc_state_e was;
        was = state;
        @(posedge mclk);
        evt <= v;
        @(posedge mclk);
        evt <= '0;
        #1;
        `CHK("state", want, state)
        `CHK("cyclic", v[2] && was == ST_DATA_EXCH, cyclic_pulse)
        `CHK("acyclic", v[1] && was == ST_DATA_EXCH, acyclic_pulse)
        t = 0;
        b = lamps.bus_fault_lamp;
        repeat (16) begin
            @(posedge mclk);
            #1;
            t += int'(lamps.bus_fault_lamp !== b);
            b = lamps.bus_fault_lamp;
        end
        `CHK("flash", want inside {ST_WAIT_CFG, ST_PROTOCOL_ERR}, t > 1)
        `CHK("green", 1'b1, lamps.activity)
    endtask

    task automatic finish_test();
        $display("Counts: %0d compared, %0d bad", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        // Address corners with every baud code, then random switch settings.
        for (i = 0; i < 16; i++) begin
            s = 9'(rnd());
            f = i < 4 ? 1'b1 : 1'(rnd());
            if (i < 4) s = {2'(i), corner[i]};
            @(posedge mclk);
            dip_sw <= s;
            serial_fitted <= f;
            repeat (7) @(posedge mclk);
            #1;
            b = s[6:0] < 7'h03 || s[6:0] > 7'h7D;
            `CHK("addr", s[6:0], node_addr)
            `CHK("sel", f ? s[8:7] : 2'h0, serial_baud_sel)
            `CHK("baud", exp_baud(f, s[8:7]), serial_baud)
            `CHK("baud sw", f && s[8:7] == 2'h0, serial_baud_sw)
            `CHK("fault", b, state == ST_FAULT)
            `CHK("sys lamp", b, lamps.system_fault_lamp)
        end
        $display("Switch decoding done");
        // State walk: every event kind from a valid address.
        @(posedge mclk);
        dip_sw <= 9'h0A5;
        repeat (8) @(posedge mclk);
        for (i = 0; i < 11; i++) step(evs[i], sts[i]);
        // Each fault source in turn forces the fault state.
        for (i = 0; i < 3; i++) begin
            @(posedge mclk);
            faults <= 3'(1 << i);
            repeat (3) @(posedge mclk);
            #1;
            `CHK("src fault", ST_FAULT, state)
            `CHK("sys lamp", 1'b1, lamps.system_fault_lamp)
            @(posedge mclk);
            faults <= '0;
            repeat (2) @(posedge mclk);
            #1;
            `CHK("recover", ST_WAIT_PARAM, state)
        end
        // A low clock enable freezes the machine, so a telegram then is lost.
        @(posedge mclk);
        clk_en <= 1'b0;
        @(posedge mclk);
        evt <= 7'h40;
        @(posedge mclk);
        evt <= '0;
        repeat (2) @(posedge mclk);
        #1;
        `CHK("frozen", ST_WAIT_PARAM, state)
        @(posedge mclk);
        clk_en <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        `CHK("thawed", ST_WAIT_PARAM, state)
        $display("State walk done");
        // Rate detection; the slowest rate is left out to keep the run short.
        for (i = 1; i < NUM_RATES; i++) begin
            @(posedge mclk);
            idx <= 4'(i);
            go <= 1'b1;
            for (t = 0; t < 8 * BIT_CYC[i] && rate_locked !== 1'b1; t++) @(posedge mclk);
            if (rate_locked !== 1'b1) begin
                mismatches++;
                $display("BAD lock exp 1 got 0");
                break;
            end
            `CHK("rate", 4'(i), rate_index)
            // The line's return to idle makes one short gap; let it pass before
            // the timeout clears the shortest gap, or it would skew the next rate.
            go <= 1'b0;
            repeat (8) @(posedge mclk);
            evt <= 7'h01;
            @(posedge mclk);
            evt <= '0;
            repeat (4) @(posedge mclk);
        end
        $display("Rate detection done");
        finish_test();
    end
endmodule
